// ---- logic/owdbg_pkg.sv ----
// Purpose: types of the one-wire debug port
// Assumes: nothing
// Notes: command decoder state encoding
`default_nettype none
package owdbg_pkg;
  typedef enum logic [2:0] {
    OWD_ST_CMD = 3'b001,
    OWD_ST_ARG = 3'b010,
    OWD_ST_ACT = 3'b100
  } owdbg_state_t;
endpackage
`default_nettype wire

// ---- logic/owdbg_port.sv ----
// Purpose: device end of the one-wire debug port on the shared reset pin
// Assumes: inputs synchronous to sys_clk; line level seen on debug_line_in
// Notes: frame is a low start bit, 8 data bits lsb first, high stop bit
`timescale 1ns/100ps
`include "owdbg_regs.svh"
`default_nettype none
module owdbg_port #(
  parameter int BIT_CYC = `OWD_BIT_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic one_wire_debug_fuse,
  input wire logic lock_bits_unprog,
  input wire logic ext_reset_n,
  input wire logic debug_line_in,
  input wire logic core_trap,
  input wire logic core_dcr_wr,
  input wire logic [7:0] core_dcr_data,
  output logic debug_line_out,
  output logic debug_line_oe_n,
  output logic pullup_en,
  output logic debug_active,
  output logic core_reset_n,
  output logic sleep_clk_keep,
  output logic core_halt,
  output logic exec_valid,
  output logic [`OWD_INSTR_W-1:0] exec_instr,
  output logic flash_wr,
  output logic [15:0] flash_addr,
  output logic [15:0] flash_data
);
  // the bit counter is OWD_CNT_W wide and the mid-bit sample needs a few cycles
  if (BIT_CYC < 4 || BIT_CYC > 255) begin : g_bad_bit_cyc
    $error("owdbg_port: BIT_CYC out of range");
  end

  localparam logic [`OWD_CNT_W-1:0] BIT_LAST = `OWD_CNT_W'(BIT_CYC - 1);
  localparam logic [`OWD_CNT_W-1:0] BIT_HALF = `OWD_CNT_W'(BIT_CYC / 2);

  // activation and pin reconfiguration; the sleep clock is kept by the debug fuse alone, whatever the lock bits
  wire next_active = one_wire_debug_fuse & lock_bits_unprog;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      debug_active <= 1'b0;
      pullup_en <= 1'b0;
      core_reset_n <= 1'b0;
      sleep_clk_keep <= 1'b0;
      debug_line_out <= 1'b0;
    end else begin
      debug_active <= next_active;
      pullup_en <= next_active;
      core_reset_n <= next_active | ext_reset_n;
      sleep_clk_keep <= one_wire_debug_fuse;
      debug_line_out <= 1'b0;
    end
  end

  // receiver
  logic rx_busy, rx_done;
  logic [3:0] rx_idx;
  logic [`OWD_CNT_W-1:0] rx_cnt;
  logic [7:0] rx_shift;
  logic tx_busy, tx_pend;
  wire rx_sample = rx_busy && rx_cnt == BIT_HALF;
  wire rx_stop = rx_sample && rx_idx == `OWD_STOP_IDX;
  wire rx_glitch = rx_sample && rx_idx == 4'h0 && debug_line_in;
  wire rx_start = !rx_busy && debug_active && !debug_line_in && !tx_busy;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_busy <= 1'b0;
      rx_idx <= 4'h0;
      rx_cnt <= '0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_done <= rx_stop && debug_line_in;
      if (rx_start) begin
        rx_busy <= 1'b1;
        rx_idx <= 4'h0;
        rx_cnt <= '0;
      end else if (rx_busy) begin
        rx_cnt <= (rx_cnt == BIT_LAST) ? '0 : rx_cnt + 1'b1;
        if (rx_stop || rx_glitch) begin
          rx_busy <= 1'b0;
        end else if (rx_sample) begin
          rx_idx <= rx_idx + 4'h1;
          if (rx_idx != 4'h0) begin
            rx_shift <= {debug_line_in, rx_shift[7:1]};
          end
        end
      end
    end
  end

  // command decoder
  owdbg_pkg::owdbg_state_t state, next_state;
  logic [7:0] cmd;
  logic [2:0] arg_left;
  logic [`OWD_ARG_W-1:0] arg_buf;
  wire [2:0] cmd_args =
    (rx_shift == `OWD_CMD_EXEC || rx_shift == `OWD_CMD_SAVE_INSTR) ? `OWD_ARGS_WORD :
    (rx_shift == `OWD_CMD_FLASH) ? `OWD_ARGS_FLASH : `OWD_ARGS_NONE;

  always_comb begin
    next_state = state;
    unique case (state)
      owdbg_pkg::OWD_ST_CMD: begin
        if (rx_done) begin
          next_state = (cmd_args == `OWD_ARGS_NONE) ? owdbg_pkg::OWD_ST_ACT
                                                    : owdbg_pkg::OWD_ST_ARG;
        end
      end
      owdbg_pkg::OWD_ST_ARG: begin
        if (rx_done && arg_left == 3'h1) begin
          next_state = owdbg_pkg::OWD_ST_ACT;
        end
      end
      owdbg_pkg::OWD_ST_ACT: next_state = owdbg_pkg::OWD_ST_CMD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= owdbg_pkg::OWD_ST_CMD;
      cmd <= 8'h00;
      arg_left <= 3'h0;
      arg_buf <= '0;
    end else begin
      state <= debug_active ? next_state : owdbg_pkg::OWD_ST_CMD;
      if (state == owdbg_pkg::OWD_ST_CMD && rx_done) begin
        cmd <= rx_shift;
        arg_left <= cmd_args;
      end else if (state == owdbg_pkg::OWD_ST_ARG && rx_done) begin
        arg_buf <= {arg_buf[`OWD_ARG_W-9:0], rx_shift};
        arg_left <= arg_left - 3'h1;
      end
    end
  end

  // actions; exec and flash only while halted so a running core is never disturbed
  wire act = state == owdbg_pkg::OWD_ST_ACT;
  wire act_halt = act && cmd == `OWD_CMD_HALT;
  wire act_resume = act && cmd == `OWD_CMD_RESUME && core_halt;
  wire act_exec = act && cmd == `OWD_CMD_EXEC && core_halt;
  wire act_flash = act && cmd == `OWD_CMD_FLASH && core_halt;
  wire act_save = act && cmd == `OWD_CMD_SAVE_INSTR;
  wire act_read = act && cmd == `OWD_CMD_READ_DCR;
  wire trap_hit = debug_active && core_trap && !core_halt;
  logic [`OWD_INSTR_W-1:0] saved_instr;
  logic [7:0] dcr;
  logic dcr_full;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_halt <= 1'b0;
      exec_valid <= 1'b0;
      exec_instr <= `OWD_INSTR_RST;
      flash_wr <= 1'b0;
      flash_addr <= 16'h0000;
      flash_data <= 16'h0000;
      saved_instr <= `OWD_INSTR_RST;
    end else begin
      exec_valid <= act_resume || act_exec;
      flash_wr <= act_flash;
      if (!debug_active) begin
        core_halt <= 1'b0;
      end else if (trap_hit || act_halt) begin
        core_halt <= 1'b1;
      end else if (act_resume) begin
        core_halt <= 1'b0;
      end
      if (act_resume) begin
        exec_instr <= saved_instr;
      end else if (act_exec) begin
        exec_instr <= arg_buf[`OWD_INSTR_W-1:0];
      end
      if (act_flash) begin
        flash_addr <= arg_buf[31:16];
        flash_data <= arg_buf[15:0];
      end
      if (act_save) begin
        saved_instr <= arg_buf[`OWD_INSTR_W-1:0];
      end
    end
  end

  // data channel: program writes, only the debugger reads; a write beats a read clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dcr <= `OWD_DCR_RST;
      dcr_full <= 1'b0;
    end else begin
      if (core_dcr_wr) begin
        dcr <= core_dcr_data;
      end
      dcr_full <= core_dcr_wr || (dcr_full && !act_read);
    end
  end

  // transmitter; a zero bit pulls low, a one bit only releases the line
  logic [7:0] tx_data;
  logic [9:0] tx_frame;
  logic [3:0] tx_idx;
  logic [`OWD_CNT_W-1:0] tx_cnt;
  wire tx_req = trap_hit || act_read;
  wire [7:0] tx_req_data = trap_hit ? `OWD_BREAK_NOTE : dcr;
  // a frame that starts in the same cycle keeps the line, so the reply waits
  wire tx_load = tx_pend && !tx_busy && !rx_busy && !rx_start;
  wire tx_bit_end = tx_busy && tx_cnt == BIT_LAST;
  wire next_oe_n = !(debug_active && tx_busy && !tx_frame[0]);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_pend <= 1'b0;
      tx_data <= 8'h00;
      tx_busy <= 1'b0;
      tx_frame <= 10'h3ff;
      tx_idx <= 4'h0;
      tx_cnt <= '0;
      debug_line_oe_n <= 1'b1;
    end else begin
      debug_line_oe_n <= next_oe_n;
      tx_pend <= tx_req || (tx_pend && !tx_load);
      if (tx_req) begin
        tx_data <= tx_req_data;
      end
      if (tx_load) begin
        tx_busy <= 1'b1;
        tx_frame <= {1'b1, tx_data, 1'b0};
        tx_idx <= 4'h0;
        tx_cnt <= '0;
      end else if (tx_busy) begin
        tx_cnt <= tx_bit_end ? '0 : tx_cnt + 1'b1;
        if (tx_bit_end) begin
          tx_frame <= {1'b1, tx_frame[9:1]};
          tx_idx <= tx_idx + 4'h1;
          tx_busy <= tx_idx != `OWD_STOP_IDX;
        end
      end
    end
  end

  default clocking owd_cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_resume_cmd;
    act_resume;
  endsequence
  sequence s_saved_runs;
    exec_valid && exec_instr == $past(saved_instr) && !core_halt;
  endsequence

  a_gate_activation: assert property (!lock_bits_unprog |=> !debug_active && !pullup_en)
    else $error("debug active with lock bits programmed");
  a_idle_line_free: assert property (!debug_active |=> debug_line_oe_n)
    else $error("line pulled while debug inactive");
  a_never_drive_high: assert property (!debug_line_oe_n |-> !debug_line_out)
    else $error("line driven high");
  a_ext_reset_blocked: assert property (debug_active |-> core_reset_n)
    else $error("external reset reached core while debugging");
  a_sleep_clock_kept: assert property (one_wire_debug_fuse |=> sleep_clk_keep)
    else $error("sleep clock dropped with debug fuse programmed");
  a_trap_halts: assert property (trap_hit |=> core_halt ##1 core_halt)
    else $error("trap did not halt core");
  a_resume_saved: assert property (s_resume_cmd |=> s_saved_runs)
    else $error("resume did not run saved instruction");
  a_exec_only_halted: assert property ((exec_valid || flash_wr) |-> $past(core_halt))
    else $error("exec or flash while running");
  a_dcr_write_wins: assert property (core_dcr_wr |=> dcr_full && dcr == $past(core_dcr_data))
    else $error("data channel write lost");
  a_start_bit_low: assert property ($rose(tx_busy) && debug_active |=> (!debug_line_oe_n)[*2])
    else $error("start bit not pulled low");
endmodule // owdbg_port
`default_nettype wire

// ---- logic/owdbg_regs.svh ----
// Purpose: named constants of the one-wire debug port
// Assumes: 25 MHz sys_clk
// Notes: line framing and command codes are local to this port
`ifndef OWDBG_REGS_SVH
`define OWDBG_REGS_SVH

`define OWD_BIT_CYC 16
`define OWD_CNT_W 8
`define OWD_STOP_IDX 4'h9
`define OWD_INSTR_W 16
`define OWD_ARG_W 32

`define OWD_CMD_HALT 8'h01
`define OWD_CMD_RESUME 8'h02
`define OWD_CMD_EXEC 8'h03
`define OWD_CMD_FLASH 8'h04
`define OWD_CMD_READ_DCR 8'h05
`define OWD_CMD_SAVE_INSTR 8'h06

`define OWD_ARGS_NONE 3'h0
`define OWD_ARGS_WORD 3'h2
`define OWD_ARGS_FLASH 3'h4

`define OWD_BREAK_NOTE 8'h55
`define OWD_DCR_RST 8'h00
`define OWD_INSTR_RST 16'h0000

`endif

// ---- test/owdbg_emu.sv ----
// Purpose: emulator end of the one-wire debug line
// Assumes: frame of low start, 8 bits lsb first, high stop; BIT_CYC clocks per bit
// Notes: only ever pulls low or releases, so the pull-up gives the high level
`timescale 1ns/100ps
`default_nettype none
module owdbg_emu #(
  parameter int BIT_CYC = 16
) (
  input wire logic sys_clk,
  input wire logic line,
  output logic pull
);
  initial pull = 1'b0;

  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      pull = ~fr[i];
      repeat (BIT_CYC - 1) @(negedge sys_clk);
    end
  endtask

  // bounded wait for the start edge; a silent device returns ok low
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line !== 1'b0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge sys_clk);
        b[i] = line;
      end
      repeat (BIT_CYC) @(posedge sys_clk);
      ok = line;
      // let the device finish its stop bit before talking again
      repeat (BIT_CYC / 2) @(posedge sys_clk);
    end
  endtask
endmodule // owdbg_emu
`default_nettype wire

// ---- test/test_one_wire_debug_port.sv ----
// Purpose: self-checking bench of the one-wire debug port
// Assumes: 25 MHz sys_clk, inputs driven at the falling edge
// Notes: pulse outputs are counted by a monitor so no cycle is missed
`timescale 1ns/100ps
`default_nettype none
module test_one_wire_debug_port;
  localparam int BC = 16;
  logic sys_clk = 1'b0;
  logic nrst, fuse, lock_ok, ext_rst_n, trap, dcr_wr;
  logic pull, out, oe_n, pu, act, crst_n, keep, halt, ev, fw;
  logic [7:0] dcr_d;
  logic [15:0] instr, fa, fd, l_instr, l_fa, l_fd;
  wire line_lvl;
  int mismatches = 0, n_checks = 0, n_exec = 0, n_flash = 0;

  always #20 sys_clk = ~sys_clk;
  // wired-and: either party pulling wins, otherwise the pull-up
  assign line_lvl = (pull || oe_n === 1'b0) ? 1'b0 : 1'b1;

  owdbg_port #(.BIT_CYC(BC)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .one_wire_debug_fuse(fuse), .lock_bits_unprog(lock_ok), .ext_reset_n(ext_rst_n),
    .debug_line_in(line_lvl), .core_trap(trap), .core_dcr_wr(dcr_wr),
    .core_dcr_data(dcr_d), .debug_line_out(out), .debug_line_oe_n(oe_n),
    .pullup_en(pu), .debug_active(act), .core_reset_n(crst_n), .sleep_clk_keep(keep),
    .core_halt(halt), .exec_valid(ev), .exec_instr(instr), .flash_wr(fw),
    .flash_addr(fa), .flash_data(fd));
  owdbg_emu #(.BIT_CYC(BC)) emu (.sys_clk(sys_clk), .line(line_lvl), .pull(pull));

  always @(posedge sys_clk) begin
    if (ev === 1'b1) begin
      n_exec++;
      l_instr = instr;
    end
    if (fw === 1'b1) begin
      n_flash++;
      l_fa = fa;
      l_fd = fd;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic t_enable;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      {ext_rst_n, fuse, lock_ok} = i[2:0];
      repeat (2) @(negedge sys_clk);
      chk("active", 32'(fuse & lock_ok), 32'(act));
      chk("pullup", 32'(fuse & lock_ok), 32'(pu));
      chk("sleep_keep", 32'(fuse), 32'(keep));
      chk("core_rst_n", 32'((fuse & lock_ok) | ext_rst_n), 32'(crst_n));
      chk("line_out", 32'h0, 32'(out));
      chk("oe_n", 32'h1, 32'(oe_n));
    end
    ext_rst_n = 1'b1;
  endtask

  task automatic t_trap_resume;
    logic [7:0] b;
    logic ok;
    int e0;
    @(negedge sys_clk);
    trap = 1'b1;
    @(negedge sys_clk);
    trap = 1'b0;
    chk("halt_trap", 32'h1, 32'(halt));
    emu.recv(b, ok);
    chk("break_note", {23'h0, 1'b1, 8'h55}, {23'h0, ok, b});
    emu.send(8'h06);
    emu.send(8'hab);
    emu.send(8'hcd);
    e0 = n_exec;
    emu.send(8'h02);
    repeat (4) @(negedge sys_clk);
    chk("resume_exec", 32'(e0 + 1), 32'(n_exec));
    chk("saved_instr", 32'h0000abcd, 32'(l_instr));
    chk("halt_resume", 32'h0, 32'(halt));
  endtask

  task automatic t_exec_flash;
    int e0;
    emu.send(8'h01);
    repeat (4) @(negedge sys_clk);
    chk("halt_cmd", 32'h1, 32'(halt));
    e0 = n_exec;
    emu.send(8'h03);
    emu.send(8'h12);
    emu.send(8'h34);
    repeat (4) @(negedge sys_clk);
    chk("exec_count", 32'(e0 + 1), 32'(n_exec));
    chk("exec_instr", 32'h00001234, 32'(l_instr));
    // debugger rewrites a breakpoint word in flash
    emu.send(8'h04);
    emu.send(8'h00);
    emu.send(8'h10);
    emu.send(8'hbe);
    emu.send(8'hef);
    repeat (4) @(negedge sys_clk);
    chk("flash_wr", 32'h1, 32'(n_flash));
    chk("flash_word", 32'h0010beef, {l_fa, l_fd});
    emu.send(8'h02);
    repeat (4) @(negedge sys_clk);
    e0 = n_exec;
    emu.send(8'h03);
    emu.send(8'h56);
    emu.send(8'h78);
    repeat (4) @(negedge sys_clk);
    chk("run_no_exec", 32'(e0), 32'(n_exec));
    chk("run_halt", 32'h0, 32'(halt));
  endtask

  // reset in mid-run while halted, then the port must come back by itself
  task automatic t_reset;
    emu.send(8'h01);
    repeat (4) @(negedge sys_clk);
    chk("halt_pre_rst", 32'h1, 32'(halt));
    nrst = 1'b0;
    @(negedge sys_clk);
    chk("rst_active", 32'h0, 32'(act));
    chk("rst_halt", 32'h0, 32'(halt));
    chk("rst_oe_n", 32'h1, 32'(oe_n));
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("rel_active", 32'h1, 32'(act));
    chk("rel_core_rst_n", 32'h1, 32'(crst_n));
  endtask

  task automatic t_dcr;
    logic [7:0] b;
    logic ok;
    @(negedge sys_clk);
    dcr_d = 8'h3c;
    dcr_wr = 1'b1;
    @(negedge sys_clk);
    dcr_wr = 1'b0;
    emu.send(8'h05);
    emu.recv(b, ok);
    chk("dcr_read", {23'h0, 1'b1, 8'h3c}, {23'h0, ok, b});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_of_test;
  end

  initial begin
    nrst = 1'b0;
    fuse = 1'b0;
    lock_ok = 1'b1;
    ext_rst_n = 1'b1;
    trap = 1'b0;
    dcr_wr = 1'b0;
    dcr_d = 8'h00;
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    t_enable;
    t_trap_resume;
    t_exec_flash;
    t_reset;
    t_dcr;
    end_of_test;
  end
endmodule // test_one_wire_debug_port
`default_nettype wire
